// ### hw/bcs_charger.sv
// Charger state sequencing, indicators and AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "bcs_consts.svh"

// Operation
// - Adapter power wins over USB; USB only without adapter.
// - Red on with power in normal charge or complete states.
// - No adapter and no USB: red and green both off.
// - Blink means equal on and off halves at one hertz.
// - Green blinks in constant voltage, off in prequal and full rate.
// - Green steady on in top-off and cycle complete.
// - Temperature, thermal or timer fault: red blinks, green off.
// - Below full-rate threshold prequalify: 10% adapter or 50 mA USB.
// - Prequalification state code is 001.
// - Reaching full-rate threshold moves prequal to full rate.
// - Full-rate state code is 010.
// - Full-rate current field resets to the 100 mA setting.
// - Two-bit field picks termination; reaching it enters constant voltage.
// - Constant-voltage state code is 011.
// - At end-of-charge current run 21 min top-off, then complete.
// - Top-off state code is 111.
// - Cycle complete stops charging regardless of enable; code 101.
// - In complete, falling below restart resumes at full rate.
// - Charge only inside 0-50 C window, narrowed to 45 C by bit.
// - Temperature out of range suspends charging, code 100.
// - Clearing enable reads code 000; setting it resumes charging.
// - Safety timer: one hour prequal, ten hours total; expiry flagged.
module bcs_charger #(
  parameter int HALF_SEC_CYCLES = `BCS_HALF_CYC
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire bcs_pkg::bcs_sense_type sense_i,
  output logic                        timer_expired_o,
  output bcs_pkg::bcs_drive_type      drive_o,
  output bcs_pkg::bcs_code_type       code_o,
  output bcs_pkg::bcs_led_type        led_o,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [3:0]             s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [3:0]             s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp
);
  import bcs_pkg::*;

  localparam int HALF_LAST = HALF_SEC_CYCLES - 1;

  function automatic logic [2:0] code_of(input bcs_state_type s);
    case (s)
      BCS_PREQ:   code_of = `BCS_CODE_PREQ;
      BCS_FULL:   code_of = `BCS_CODE_FULL;
      BCS_CV:     code_of = `BCS_CODE_CV;
      BCS_TOPOFF: code_of = `BCS_CODE_TOPOFF;
      BCS_DONE:   code_of = `BCS_CODE_DONE;
      BCS_TEMP:   code_of = `BCS_CODE_TEMP;
      BCS_FAULT:  code_of = `BCS_CODE_FAULT;
      default:    code_of = `BCS_CODE_OFF;
    endcase
  endfunction : code_of

  function automatic logic is_charging(input bcs_state_type s);
    is_charging = (s == BCS_PREQ) || (s == BCS_FULL) ||
                  (s == BCS_CV) || (s == BCS_TOPOFF);
  endfunction : is_charging

  bcs_state_type         state;
  bcs_state_type         next_state;
  logic [7:0]            ctrl;
  logic                  narrow;
  logic                  timed_out;
  logic                  tmo_flag;
  logic [24:0]           half_cnt;
  logic                  half_tick;
  logic                  blink;
  logic [`BCS_TMR_W-1:0] safe_cnt;
  logic [`BCS_TMR_W-1:0] preq_cnt;
  logic [`BCS_TMR_W-1:0] topoff_cnt;
  logic                  topoff_done;
  logic                  expire;
  logic                  pwr;
  logic                  temp_ok;
  logic                  run_ok;
  logic                  src_adapter;
  logic                  src_change;
  logic                  aw_hold;
  logic                  w_hold;
  logic [3:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  wr_en;
  logic                  wr_lane0;
  logic                  ar_take;

  ////////////////////////////////////////////////////////////////////////
  // Blink divider, free running so both LEDs share one phase
  assign half_tick = (half_cnt == 25'(HALF_LAST));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      half_cnt <= 25'h0000000;
      blink    <= 1'b0;
    end else begin
      half_cnt <= half_tick ? 25'h0000000 : half_cnt + 25'h0000001;
      if (half_tick) begin
        blink <= ~blink;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conditions
  assign pwr        = sense_i.adapter | sense_i.usb;
  assign temp_ok    = !sense_i.temp_cold &&
                      !(narrow ? sense_i.temp_hot45 : sense_i.temp_hot50);
  assign run_ok     = pwr && ctrl[`BCS_CTRL_EN] && !sense_i.thermal_sd &&
                      !timed_out && temp_ok;
  assign src_change = pwr && (src_adapter != sense_i.adapter);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      src_adapter <= 1'b0;
    end else begin
      src_adapter <= sense_i.adapter;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Charge sequence
  always_comb begin
    next_state = state;
    if (!pwr || !ctrl[`BCS_CTRL_EN]) begin
      next_state = BCS_OFF;
    end else if (sense_i.thermal_sd || timed_out) begin
      next_state = BCS_FAULT;
    end else if (!temp_ok) begin
      next_state = BCS_TEMP;
    end else begin
      case (state)
        BCS_OFF, BCS_TEMP, BCS_FAULT: begin
          next_state = sense_i.above_full ? BCS_FULL : BCS_PREQ;
        end
        BCS_PREQ: begin
          if (sense_i.above_full) begin
            next_state = BCS_FULL;
          end
        end
        BCS_FULL: begin
          if (sense_i.at_term) begin
            next_state = BCS_CV;
          end
        end
        BCS_CV: begin
          if (sense_i.at_eoc) begin
            next_state = BCS_TOPOFF;
          end
        end
        BCS_TOPOFF: begin
          if (topoff_done) begin
            next_state = BCS_DONE;
          end
        end
        BCS_DONE: begin
          if (sense_i.below_restart) begin
            next_state = BCS_FULL;
          end
        end
        default: next_state = BCS_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= BCS_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Top-off interval and safety timer, counted in half seconds
  assign topoff_done = half_tick &&
                       (topoff_cnt == `BCS_TMR_W'(`BCS_TOPOFF_HALVES - 1));
  assign expire = is_charging(state) && half_tick &&
    ((safe_cnt == `BCS_TMR_W'(`BCS_TOTAL_HALVES - 1)) ||
     (state == BCS_PREQ &&
      preq_cnt == `BCS_TMR_W'(`BCS_PREQ_HALVES - 1)));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      topoff_cnt <= '0;
    end else if (state != BCS_TOPOFF) begin
      topoff_cnt <= '0;
    end else if (half_tick) begin
      topoff_cnt <= topoff_cnt + `BCS_TMR_W'(1);
    end
  end

  // Prequal time also counts toward the total, so total is ten hours
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      safe_cnt <= '0;
      preq_cnt <= '0;
    end else if (!is_charging(state) || src_change) begin
      safe_cnt <= '0;
      preq_cnt <= '0;
    end else if (half_tick) begin
      safe_cnt <= safe_cnt + `BCS_TMR_W'(1);
      if (state == BCS_PREQ) begin
        preq_cnt <= preq_cnt + `BCS_TMR_W'(1);
      end
    end
  end

  // Expiry latches until enable toggles, power drops or source swaps
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      timed_out       <= 1'b0;
      timer_expired_o <= 1'b0;
    end else begin
      timer_expired_o <= expire;
      if (expire) begin
        timed_out <= 1'b1;
      end else if (!pwr || !ctrl[`BCS_CTRL_EN] || src_change) begin
        timed_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs toward the power stage, code and indicators
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_o <= '0;
      code_o  <= '0;
      led_o   <= '0;
    end else begin
      drive_o.use_adapter <= sense_i.adapter;
      drive_o.use_usb     <= sense_i.usb && !sense_i.adapter;
      drive_o.charge_on   <= is_charging(next_state);
      drive_o.preq_tenth  <= next_state == BCS_PREQ && sense_i.adapter;
      drive_o.preq_usb50  <= next_state == BCS_PREQ && !sense_i.adapter;
      drive_o.rate_code   <= ctrl[`BCS_CTRL_RATE_HI:`BCS_CTRL_RATE_LO];
      drive_o.term_sel    <= ctrl[`BCS_CTRL_TERM_HI:`BCS_CTRL_TERM_LO];
      drive_o.eoc_tenth   <= ctrl[`BCS_CTRL_EOC];
      code_o              <= code_of(next_state);
      if (!pwr) begin
        led_o <= '0;
      end else begin
        case (state)
          BCS_TEMP, BCS_FAULT: led_o <= '{blink, 1'b0};
          BCS_CV:              led_o <= '{1'b1, blink};
          BCS_TOPOFF, BCS_DONE: led_o <= '{1'b1, 1'b1};
          default:             led_o <= '{1'b1, 1'b0};
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en         = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_lane0      = wr_en && w_strb[0];
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BCS_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `BCS_ADDR_CTRL ||
                         aw_addr == `BCS_ADDR_SUPV ||
                         aw_addr == `BCS_ADDR_STAT) ?
                        `BCS_RESP_OK : `BCS_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl   <= `BCS_CTRL_RST;
      narrow <= `BCS_SUPV_RST;
    end else if (wr_lane0 && aw_addr == `BCS_ADDR_CTRL) begin
      ctrl <= w_data[7:0];
    end else if (wr_lane0 && aw_addr == `BCS_ADDR_SUPV) begin
      narrow <= w_data[`BCS_SUPV_NARROW];
    end
  end

  // Expiry flag: a new expiry wins over a write-one clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tmo_flag <= 1'b0;
    end else if (expire) begin
      tmo_flag <= 1'b1;
    end else if (wr_lane0 && aw_addr == `BCS_ADDR_STAT &&
                 w_data[`BCS_STAT_TMO]) begin
      tmo_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `BCS_RESP_OK;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `BCS_RESP_OK;
      case (s_axi_araddr)
        `BCS_ADDR_CTRL: s_axi_rdata <= {24'h000000, ctrl};
        `BCS_ADDR_SUPV: s_axi_rdata <= {25'h0000000, code_o, narrow, 3'h0};
        `BCS_ADDR_STAT: s_axi_rdata <= {28'h0000000, drive_o.charge_on,
                          drive_o.use_usb, drive_o.use_adapter, tmo_flag};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BCS_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence topoff_end_s;
    state == BCS_TOPOFF && topoff_done && run_ok;
  endsequence

  sequence done_restart_s;
    state == BCS_DONE && sense_i.below_restart && run_ok;
  endsequence

  src_prio_a: assert property (sense_i.adapter |=>
    drive_o.use_adapter && !drive_o.use_usb)
    else $error("USB chosen while adapter present");
  leds_off_a: assert property (!pwr |=> led_o == '0)
    else $error("Indicator lit without power");
  blink_step_a: assert property ($changed(blink) |-> $past(half_tick))
    else $error("Blink toggled off the half-second tick");
  green_cv_a: assert property (pwr && state == BCS_CV |=>
    led_o.green == $past(blink) && led_o.red_indicator_pin)
    else $error("Green not blinking in constant voltage");
  green_full_a: assert property (pwr && state == BCS_DONE |=>
    led_o.green) else $error("Green not steady when complete");
  fault_led_a: assert property (pwr && state == BCS_FAULT |=>
    led_o == {$past(blink), 1'b0})
    else $error("Fault indicators wrong");
  preq_exit_a: assert property (state == BCS_PREQ && run_ok &&
    sense_i.above_full |=> state == BCS_FULL && code_o == 3'h2)
    else $error("Prequal did not move to full rate");
  topoff_end_a: assert property (topoff_end_s |=>
    state == BCS_DONE && code_o == 3'h5 && !drive_o.charge_on)
    else $error("Top-off did not complete");
  restart_a: assert property (done_restart_s |=> state == BCS_FULL)
    else $error("No restart from complete");
  temp_stop_a: assert property (pwr && ctrl[`BCS_CTRL_EN] &&
    !sense_i.thermal_sd && !timed_out && !temp_ok |=>
    code_o == 3'h4 && !drive_o.charge_on)
    else $error("Charging outside temperature window");
  disable_a: assert property (!ctrl[`BCS_CTRL_EN] |=> code_o == '0)
    else $error("Code not cleared when disabled");
  expire_a: assert property (expire |=> timed_out && tmo_flag ##1
    state == BCS_FAULT) else $error("Timer expiry not acted on");
endmodule : bcs_charger
`default_nettype wire

// ### hw/bcs_consts.svh
// Constants of the battery charge state control block
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH
`define BCS_CLK_HZ         40000000
`define BCS_BLINK_HZ       1
`define BCS_HALF_PER_S     2
`define BCS_TOPOFF_MIN     21
`define BCS_PREQ_MAX_HR    1
`define BCS_TOTAL_MAX_HR   10
`define BCS_HALF_CYC       (`BCS_CLK_HZ / (2 * `BCS_BLINK_HZ))
`define BCS_TOPOFF_HALVES  (`BCS_TOPOFF_MIN * 60 * `BCS_HALF_PER_S)
`define BCS_PREQ_HALVES    (`BCS_PREQ_MAX_HR * 3600 * `BCS_HALF_PER_S)
`define BCS_TOTAL_HALVES   (`BCS_TOTAL_MAX_HR * 3600 * `BCS_HALF_PER_S)
`define BCS_TMR_W          17
`define BCS_ADDR_CTRL      4'h0
`define BCS_ADDR_SUPV      4'h4
`define BCS_ADDR_STAT      4'h8
`define BCS_CTRL_RST       8'h42
`define BCS_SUPV_RST       1'b0
`define BCS_CTRL_EOC       0
`define BCS_CTRL_EN        1
`define BCS_CTRL_RATE_LO   2
`define BCS_CTRL_RATE_HI   5
`define BCS_CTRL_TERM_LO   6
`define BCS_CTRL_TERM_HI   7
`define BCS_SUPV_NARROW    3
`define BCS_SUPV_CODE_LO   4
`define BCS_STAT_TMO       0
`define BCS_RESP_OK        2'h0
`define BCS_RESP_ERR       2'h2
`define BCS_CODE_OFF       3'h0
`define BCS_CODE_PREQ      3'h1
`define BCS_CODE_FULL      3'h2
`define BCS_CODE_CV        3'h3
`define BCS_CODE_TOPOFF    3'h7
`define BCS_CODE_DONE      3'h5
`define BCS_CODE_TEMP      3'h4
`define BCS_CODE_FAULT     3'h6
`endif

// ### hw/bcs_pkg.sv
// Types of the battery charge state control block
package bcs_pkg;
  typedef enum logic [2:0] {
    BCS_OFF, BCS_PREQ, BCS_FULL, BCS_CV,
    BCS_TOPOFF, BCS_DONE, BCS_TEMP, BCS_FAULT
  } bcs_state_type;

  typedef struct packed {
    logic adapter;
    logic usb;
    logic above_full;
    logic at_term;
    logic at_eoc;
    logic below_restart;
    logic temp_cold;
    logic temp_hot45;
    logic temp_hot50;
    logic thermal_sd;
  } bcs_sense_type;

  typedef struct packed {
    logic       use_adapter;
    logic       use_usb;
    logic       charge_on;
    logic       preq_tenth;
    logic       preq_usb50;
    logic [3:0] rate_code;
    logic [1:0] term_sel;
    logic       eoc_tenth;
  } bcs_drive_type;

  typedef struct packed {
    logic charge_state_bit_high;
    logic charge_state_bit_mid;
    logic charge_state_bit_low;
  } bcs_code_type;

  typedef struct packed {
    logic red_indicator_pin;
    logic green;
  } bcs_led_type;
endpackage : bcs_pkg

// ### tb/bcs_batt_model.sv
// Behavioural battery, power sources and thermistor facing the charger
`timescale 1ns/100ps
`default_nettype none

module bcs_batt_model #(
  parameter int FULL_LVL = 16,
  parameter int TERM_LVL = 40,
  parameter int EOC_LVL  = 120
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire bcs_pkg::bcs_drive_type drive_i,
  input  wire logic                   adapter_i,
  input  wire logic                   usb_i,
  input  wire logic                   load_i,
  input  wire logic [3:0]             temp_i,
  output bcs_pkg::bcs_sense_type      sense_o
);
  import bcs_pkg::*;

  logic [7:0] lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Cell charge: rises while charged without load, falls under load only while not charged
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl <= 8'h00;
    end else if (drive_i.charge_on && !load_i && lvl < 8'(EOC_LVL + 8)) begin
      lvl <= lvl + 8'h01;
    end else if (!drive_i.charge_on && load_i && lvl != 8'h00) begin
      lvl <= lvl - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator levels; taper current reaches end of charge late in CV
  always_comb begin
    sense_o.adapter       = adapter_i;
    sense_o.usb           = usb_i;
    sense_o.above_full    = (lvl >= 8'(FULL_LVL));
    sense_o.at_term       = (lvl >= 8'(TERM_LVL));
    sense_o.at_eoc        = (lvl >= 8'(EOC_LVL));
    sense_o.below_restart = (lvl < 8'(TERM_LVL - 8));
    sense_o.temp_cold     = temp_i[3];
    sense_o.temp_hot45    = temp_i[2];
    sense_o.temp_hot50    = temp_i[1];
    sense_o.thermal_sd    = temp_i[0];
  end
endmodule : bcs_batt_model

`default_nettype wire

// ### tb/tb_battery_charge_state_control.sv
// Self-checking bench for the charge state control block
`timescale 1ns/100ps
`default_nettype none
`include "bcs_consts.svh"

module tb_battery_charge_state_control;
  import bcs_pkg::*;

  localparam int HALF = 4;
  logic          mclk_i, rst_i = 1'b1;
  logic          adapter = 1'b0, usb = 1'b0, load = 1'b0;
  logic [3:0]    temp = 4'h0, awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic          arvalid = 1'b0, rready = 1'b0;
  logic [31:0]   wdata = 32'h0, rdata, rd;
  logic          awready, wready, bvalid, arready, rvalid, tmo;
  logic [1:0]    bresp, rresp, rs;
  bcs_sense_type sense;
  bcs_drive_type drive;
  bcs_code_type  code;
  bcs_led_type   led;
  int            errors = 0, n_checks = 0, cycles = 0, n;

  bcs_charger #(.HALF_SEC_CYCLES(HALF)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .sense_i(sense),
    .timer_expired_o(tmo), .drive_o(drive), .code_o(code), .led_o(led),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  bcs_batt_model model (
    .mclk_i(mclk_i), .rst_i(rst_i), .drive_i(drive), .adapter_i(adapter),
    .usb_i(usb), .load_i(load), .temp_i(temp), .sense_o(sense));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Whole run needs roughly 40k cycles; the longest wait is the prequal timer
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      $display("Error at %0t: run did not finish", $time);
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic do_reset();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    adapter <= 1'b0;
    usb <= 1'b0;
    load <= 1'b0;
    temp <= 4'h0;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_t, w_t, aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge mclk_i);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      @(posedge mclk_i);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      aw_d = aw_d | aw_t;
      w_d = w_d | w_t;
    end
    do @(negedge mclk_i); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge mclk_i);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge mclk_i); while (arready !== 1'b1);
    @(posedge mclk_i);
    arvalid <= 1'b0;
    do @(negedge mclk_i); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    @(posedge mclk_i);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_code(input logic [2:0] c, input int lim);
    n = 0;
    while (code !== c && n < lim) begin
      @(negedge mclk_i);
      n++;
    end
    chk(code === c, "state code not reached");
  endtask : wait_code

  function automatic logic pick(input bit red);
    return red ? led.red_indicator_pin : led.green;
  endfunction : pick

  // Two passes align: entering a blink state may flip the LED mid-half
  task automatic chk_blink(input bit red);
    logic v;
    int   k;
    for (int i = 0; i < 4; i++) begin
      v = pick(red);
      k = 0;
      while (pick(red) === v && k < 4 * HALF) begin
        @(negedge mclk_i);
        k++;
      end
      if (i > 1) chk(k == HALF, "blink half period wrong");
    end
  endtask : chk_blink

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    do_reset();
    @(negedge mclk_i);
    chk(code === 3'h0 && led === 2'b00, "outputs active unpowered");
    axi_rd(`BCS_ADDR_CTRL);
    chk(rd === 32'h42 && rs === `BCS_RESP_OK, "control reset value");
    axi_rd(4'hC);
    chk(rd === 32'h0 && rs === `BCS_RESP_ERR, "unmapped read");
    axi_wr(4'hC, 32'hFF);
    chk(rs === `BCS_RESP_ERR, "unmapped write");
    $display("test regs done");
  endtask : t_regs

  task automatic t_source();
    do_reset();
    adapter <= 1'b1;
    usb <= 1'b1;
    load <= 1'b1;
    wait_code(`BCS_CODE_PREQ, 20);
    chk(drive.use_adapter === 1'b1 && drive.use_usb === 1'b0, "source");
    chk(drive.preq_tenth === 1'b1, "adapter prequal current");
    @(posedge mclk_i);
    adapter <= 1'b0;
    repeat (3) @(negedge mclk_i);
    chk(drive.use_usb === 1'b1 && drive.use_adapter === 1'b0, "usb");
    chk(drive.preq_usb50 === 1'b1, "usb prequal current");
    @(posedge mclk_i);
    usb <= 1'b0;
    wait_code(`BCS_CODE_OFF, 20);
    repeat (2) @(negedge mclk_i);
    chk(led === 2'b00, "indicators lit without power");
    $display("test source done");
  endtask : t_source

  task automatic t_cycle();
    do_reset();
    adapter <= 1'b1;
    wait_code(`BCS_CODE_PREQ, 20);
    repeat (2) @(negedge mclk_i);
    chk(led === 2'b10, "prequal indicators");
    wait_code(`BCS_CODE_FULL, 40);
    chk(drive.charge_on === 1'b1 && led === 2'b10, "full rate");
    chk({drive.term_sel, drive.rate_code, 1'b1, drive.eoc_tenth} ===
        `BCS_CTRL_RST, "control fields passed out");
    wait_code(`BCS_CODE_CV, 40);
    chk_blink(1'b0);
    chk(led.red_indicator_pin === 1'b1, "red off in CV");
    wait_code(`BCS_CODE_TOPOFF, 100);
    repeat (2) @(negedge mclk_i);
    chk(led === 2'b11, "top-off indicators");
    wait_code(`BCS_CODE_DONE, 2521 * HALF + 10);
    chk(n >= 2519 * HALF - 1 && n <= 2520 * HALF - 2, "top-off length");
    chk(drive.charge_on === 1'b0, "charging after complete");
    repeat (2) @(negedge mclk_i);
    chk(led === 2'b11, "complete indicators");
    @(posedge mclk_i);
    load <= 1'b1;
    wait_code(`BCS_CODE_FULL, 300);
    @(posedge mclk_i);
    load <= 1'b0;
    $display("test cycle done");
  endtask : t_cycle

  task automatic t_temp();
    do_reset();
    adapter <= 1'b1;
    load <= 1'b1;
    wait_code(`BCS_CODE_PREQ, 20);
    @(posedge mclk_i);
    temp <= 4'h2;
    wait_code(`BCS_CODE_TEMP, 20);
    chk(drive.charge_on === 1'b0, "charging while hot");
    repeat (2) @(negedge mclk_i);
    chk(led.green === 1'b0, "green lit on fault");
    chk_blink(1'b1);
    @(posedge mclk_i);
    temp <= 4'h4;
    wait_code(`BCS_CODE_PREQ, 20);
    axi_wr(`BCS_ADDR_SUPV, 32'h08);
    wait_code(`BCS_CODE_TEMP, 20);
    axi_rd(`BCS_ADDR_SUPV);
    chk(rd === 32'h48, "supervisory readback");
    @(posedge mclk_i);
    temp <= 4'h1;
    wait_code(`BCS_CODE_FAULT, 20);
    chk_blink(1'b1);
    $display("test temp done");
  endtask : t_temp

  task automatic t_disable();
    do_reset();
    adapter <= 1'b1;
    load <= 1'b1;
    wait_code(`BCS_CODE_PREQ, 20);
    axi_wr(`BCS_ADDR_CTRL, 32'h40);
    wait_code(`BCS_CODE_OFF, 20);
    chk(drive.charge_on === 1'b0, "charging while disabled");
    axi_wr(`BCS_ADDR_CTRL, 32'h42);
    wait_code(`BCS_CODE_PREQ, 20);
    chk(drive.charge_on === 1'b1, "no resume");
    $display("test disable done");
  endtask : t_disable

  task automatic t_timer();
    do_reset();
    adapter <= 1'b1;
    load <= 1'b1;
    n = 0;
    while (tmo !== 1'b1 && n < 7201 * HALF + 50) begin
      @(negedge mclk_i);
      n++;
    end
    chk(tmo === 1'b1 && n >= 7199 * HALF, "prequal timer");
    wait_code(`BCS_CODE_FAULT, 5);
    axi_rd(`BCS_ADDR_STAT);
    chk(rd[0] === 1'b1, "expiry not flagged");
    axi_wr(`BCS_ADDR_STAT, 32'h1);
    axi_rd(`BCS_ADDR_STAT);
    chk(rd[0] === 1'b0, "expiry flag not cleared");
    chk(led.green === 1'b0, "green lit on expiry");
    chk_blink(1'b1);
    $display("test timer done");
  endtask : t_timer

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_regs();
    t_source();
    t_cycle();
    t_temp();
    t_disable();
    t_timer();
    test_done();
  end
endmodule : tb_battery_charge_state_control

`default_nettype wire
